// file: core/macrocell_pkg.sv
// Shared constants and carrier types for the output cell register block
package macrocell_pkg;
	localparam int CELLS = 10;
	localparam int ADDR_W = 8;
	localparam int PAT_WORDS = 4;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_POLARITY = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_BYPASS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_OUT_EN = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SECURE = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PATTERN = 8'h20;
	// Field positions
	localparam int SEC_FUSE_BIT = 0;
	localparam int ST_POR_DONE_BIT = 0;
	localparam int ST_PRELOAD_BIT = 1;
	localparam int ST_SECURE_BIT = 2;
	localparam int ST_CELL_LSB = 16;
	// Reset values
	localparam logic [CELLS-1:0] POLARITY_RST = 10'h000;
	localparam logic [CELLS-1:0] BYPASS_RST = 10'h000;
	localparam logic [CELLS-1:0] OUT_EN_RST = 10'h000;
	localparam logic [31:0] PATTERN_RST = 32'h0000_0000;
	// Reading a secured array returns the fully programmed pattern
	localparam logic [31:0] PATTERN_SECURED = 32'hFFFF_FFFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Power-up reset time and its cycle count at 50 MHz
	localparam int CLK_PERIOD_NS = 20;
	localparam int POR_TIME_NS = 1000;
	localparam int POR_CYCLES = POR_TIME_NS / CLK_PERIOD_NS;
	localparam int POR_CNT_W = 6;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_t;
endpackage

// file: core/macrocell_regs.sv
// Output cell flip-flops with set, clear, power-up reset, preload and AXI4-Lite control
//
// Overview of operation
// - Set and clear terms act on all cells
// - Set term loads ones at next edge
// - Clear term zeroes flip-flops without a clock
// - Pin shows stored value through polarity
// - Power-up clears every flip-flop to zero
// - Power-up reset ends within one microsecond
// - Secured array reads as fully programmed
// - Preload entry disables drivers, enables preload
// - Outputs never glitch; only delay grows
// - Cells capture only on rising clock edge
// - Polarity one active high, zero inverted
// - Bypass zero from cell flop, one from cell_next; the pin stage registers both
`timescale 1ns/1ps
module macrocell_regs
	import macrocell_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire axi_req_t axi_req,
	output axi_rsp_t axi_rsp,
	input wire logic [CELLS-1:0] cell_next,
	input wire logic sync_set_term,
	input wire logic async_clear_term,
	input wire logic preload_entry_level,
	input wire logic [CELLS-1:0] pin_in,
	output logic [CELLS-1:0] pin_out,
	output logic [CELLS-1:0] pin_oe,
	output logic [CELLS-1:0] feedback
);
	logic [CELLS-1:0] polarity_q;
	logic [CELLS-1:0] bypass_q;
	logic [CELLS-1:0] out_en_q;
	logic secure_q;
	logic [31:0] pattern_q [PAT_WORDS];
	logic [CELLS-1:0] cell_q;
	logic [CELLS-1:0] cell_d;
	logic [POR_CNT_W-1:0] por_cnt_q;
	logic por_done_q;
	logic aw_rdy_q;
	logic w_rdy_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic ar_rdy_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic rd_pattern_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [CELLS-1:0] pin_out_q;
	logic [CELLS-1:0] pin_oe_q;
	logic [CELLS-1:0] feedback_q;
	logic do_write;

	// Merge write data into an old value under byte strobes
	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		end
		return res;
	endfunction

	// True when an address falls in the pattern window
	function automatic logic is_pattern(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:4] == OFS_PATTERN[ADDR_W-1:4];
	endfunction

	// Store value that makes the pin show a given level under the polarity
	function automatic logic [CELLS-1:0] through_pol(input logic [CELLS-1:0] v, input logic [CELLS-1:0] pol);
		return v ^ ~pol;
	endfunction

	assign axi_rsp.awready = aw_rdy_q;
	assign axi_rsp.wready = w_rdy_q;
	assign axi_rsp.bvalid = bvalid_q;
	assign axi_rsp.bresp = bresp_q;
	assign axi_rsp.arready = ar_rdy_q;
	assign axi_rsp.rvalid = rvalid_q;
	assign axi_rsp.rdata = rdata_q;
	assign axi_rsp.rresp = rresp_q;
	assign pin_out = pin_out_q;
	assign pin_oe = pin_oe_q;
	assign feedback = feedback_q;

	////////////////////////////////////////////////////////////////////////////////
	// Power-up reset: cells held clear until the count runs out
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			por_cnt_q <= '0;
			por_done_q <= 1'b0;
		end
		else if (!por_done_q)
		begin
			por_cnt_q <= por_cnt_q + 1'b1;
			por_done_q <= (por_cnt_q == POR_CNT_W'(POR_CYCLES - 1));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next value of the shared cell register
	always_comb
	begin
		if (!por_done_q)
			cell_d = '0;
		else if (preload_entry_level)
			cell_d = through_pol(pin_in, polarity_q);
		else if (sync_set_term)
			cell_d = '1;
		else
			cell_d = cell_next;
	end

	// Clear term is asynchronous and outranks everything, set included
	always_ff @(posedge sys_clk or posedge async_clear_term)
	begin
		if (async_clear_term)
			cell_q <= '0;
		else if (rst)
			cell_q <= '0;
		else
			cell_q <= cell_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin stage: registered so the pin never shows a half-resolved value
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pin_out_q <= '0;
			pin_oe_q <= '0;
			feedback_q <= '0;
		end
		else
		begin
			for (int i = 0; i < CELLS; i++)
			begin
				pin_out_q[i] <= bypass_q[i] ? (cell_next[i] ~^ polarity_q[i])
					: (cell_q[i] ~^ polarity_q[i]);
				feedback_q[i] <= bypass_q[i] ? pin_in[i] : ~cell_q[i];
			end
			pin_oe_q <= preload_entry_level ? '0 : out_en_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channels, address and data taken in either order
	assign do_write = !aw_rdy_q && !w_rdy_q && !bvalid_q;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			aw_rdy_q <= 1'b1;
			w_rdy_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else
		begin
			if (aw_rdy_q && axi_req.awvalid)
			begin
				aw_rdy_q <= 1'b0;
				awaddr_q <= axi_req.awaddr;
			end
			if (w_rdy_q && axi_req.wvalid)
			begin
				w_rdy_q <= 1'b0;
				wdata_q <= axi_req.wdata;
				wstrb_q <= axi_req.wstrb;
			end
			if (do_write)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= (is_pattern(awaddr_q) || awaddr_q == OFS_POLARITY || awaddr_q == OFS_BYPASS
					|| awaddr_q == OFS_OUT_EN || awaddr_q == OFS_SECURE || awaddr_q == OFS_STATUS)
					? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && axi_req.bready)
			begin
				bvalid_q <= 1'b0;
				aw_rdy_q <= 1'b1;
				w_rdy_q <= 1'b1;
			end
		end
	end

	// Configuration registers; the security fuse is set by a write and cleared only by rst
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			polarity_q <= POLARITY_RST;
			bypass_q <= BYPASS_RST;
			out_en_q <= OUT_EN_RST;
			secure_q <= 1'b0;
			for (int i = 0; i < PAT_WORDS; i++)
				pattern_q[i] <= PATTERN_RST;
		end
		else if (do_write)
		begin
			if (awaddr_q == OFS_POLARITY)
				polarity_q <= CELLS'(apply_strb(32'(polarity_q), wdata_q, wstrb_q));
			if (awaddr_q == OFS_BYPASS)
				bypass_q <= CELLS'(apply_strb(32'(bypass_q), wdata_q, wstrb_q));
			if (awaddr_q == OFS_OUT_EN)
				out_en_q <= CELLS'(apply_strb(32'(out_en_q), wdata_q, wstrb_q));
			if (awaddr_q == OFS_SECURE && wstrb_q[0] && wdata_q[SEC_FUSE_BIT])
				secure_q <= 1'b1;
			if (is_pattern(awaddr_q))
				pattern_q[awaddr_q[3:2]] <= apply_strb(pattern_q[awaddr_q[3:2]], wdata_q, wstrb_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read: answer one cycle after the address is taken
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ar_rdy_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
			rd_pattern_q <= 1'b0;
		end
		else if (ar_rdy_q && axi_req.arvalid)
		begin
			ar_rdy_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			rd_pattern_q <= is_pattern(axi_req.araddr);
			rdata_q <= '0;
			if (is_pattern(axi_req.araddr))
				rdata_q <= secure_q ? PATTERN_SECURED : pattern_q[axi_req.araddr[3:2]];
			else if (axi_req.araddr == OFS_POLARITY)
				rdata_q <= 32'(polarity_q);
			else if (axi_req.araddr == OFS_BYPASS)
				rdata_q <= 32'(bypass_q);
			else if (axi_req.araddr == OFS_OUT_EN)
				rdata_q <= 32'(out_en_q);
			else if (axi_req.araddr == OFS_SECURE)
				rdata_q[SEC_FUSE_BIT] <= secure_q;
			else if (axi_req.araddr == OFS_STATUS)
			begin
				rdata_q[ST_POR_DONE_BIT] <= por_done_q;
				rdata_q[ST_PRELOAD_BIT] <= preload_entry_level;
				rdata_q[ST_SECURE_BIT] <= secure_q;
				rdata_q[ST_CELL_LSB +: CELLS] <= cell_q;
			end
			else
				rresp_q <= RESP_SLVERR;
		end
		else if (rvalid_q && axi_req.rready)
		begin
			rvalid_q <= 1'b0;
			ar_rdy_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the cell register and its surroundings
	a_clear_forces_zero: assert property (@(posedge sys_clk) disable iff (rst)
		async_clear_term |-> cell_q == '0) else $error("cells not zero under clear");
	a_set_loads_ones: assert property (@(posedge sys_clk) disable iff (rst)
		por_done_q && !preload_entry_level && sync_set_term && !async_clear_term
		|=> (cell_q == '1 || async_clear_term)) else $error("set term did not load ones");
	a_clear_beats_set: assert property (@(posedge sys_clk) disable iff (rst)
		sync_set_term && async_clear_term |-> cell_q == '0) else $error("set won over clear");
	a_pin_polarity: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> ((pin_out_q ^ ($past(cell_q) ^ ~$past(polarity_q))) & ~$past(bypass_q)) == '0)
		else $error("pin level not stored value through polarity");
	a_por_holds_clear: assert property (@(posedge sys_clk) disable iff (rst)
		!por_done_q |-> (cell_q == '0) && (por_cnt_q < POR_CNT_W'(POR_CYCLES)))
		else $error("cells changed during power-up reset");
	a_por_length: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(por_done_q) |-> por_cnt_q == POR_CNT_W'(POR_CYCLES)) else $error("power-up reset length wrong");
	a_secure_readback: assert property (@(posedge sys_clk) disable iff (rst)
		rvalid_q && rd_pattern_q && $past(secure_q) && !$past(rvalid_q) |-> rdata_q == PATTERN_SECURED)
		else $error("secured array read leaked pattern");
	a_preload_drivers_off: assert property (@(posedge sys_clk) disable iff (rst)
		preload_entry_level |=> pin_oe_q == '0) else $error("drivers active during preload");
	a_preload_loads_pins: assert property (@(posedge sys_clk) disable iff (rst)
		por_done_q && preload_entry_level && !async_clear_term
		|=> (cell_q == ($past(pin_in) ^ ~$past(polarity_q)) || async_clear_term))
		else $error("preload did not load pin levels");
	a_comb_feedback: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> ((feedback_q ^ $past(pin_in)) & $past(bypass_q)) == '0)
		else $error("bypass feedback not from pin");
endmodule

// file: verification/pin_partner.sv
// Far-side model: tester on the output cell pins
`timescale 1ns/1ps
module pin_partner
	import macrocell_pkg::*;
(
	input wire logic sys_clk,
	input wire logic drive_en,
	input wire logic [CELLS-1:0] drive_val,
	input wire logic [CELLS-1:0] pin_out,
	input wire logic [CELLS-1:0] pin_oe,
	output logic [CELLS-1:0] pin_in
);
	logic [CELLS-1:0] float_q = 10'h155;
	// Pins have no pull, so a released pin keeps changing
	always_ff @(posedge sys_clk)
	begin
		float_q <= ~float_q;
	end
	// Tester drives while drive_en is high, else the device or nothing
	always_comb
	begin
		for (int i = 0; i < CELLS; i++)
			pin_in[i] = drive_en ? drive_val[i] : (pin_oe[i] ? pin_out[i] : float_q[i]);
	end
endmodule

// file: verification/testbench.sv
// Bench for the output cell register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
	import macrocell_pkg::*;
	logic sys_clk = 0;
	logic rst = 1;
	axi_req_t req = '0;
	axi_rsp_t rsp;
	logic [CELLS-1:0] nxt = 10'h3FF;
	logic set_t = 0;
	logic clr_t = 0;
	logic pre = 0;
	logic drv = 0;
	logic [CELLS-1:0] dval = 10'h000;
	logic [CELLS-1:0] pin_in, pin_out, pin_oe, fb;
	logic [31:0] rd;
	logic [1:0] rr;
	int bad_count = 0;
	int comparisons = 0;

	// 50 MHz clock
	always #10 sys_clk = ~sys_clk;

	macrocell_regs u_macrocell_regs (.sys_clk(sys_clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
		.cell_next(nxt), .sync_set_term(set_t), .async_clear_term(clr_t), .preload_entry_level(pre),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .feedback(fb));
	pin_partner u_pin_partner (.sys_clk(sys_clk), .drive_en(drv), .drive_val(dval), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in(pin_in));

	////////////////////////////////////////////////////////////////
	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end
		while (!rsp.bvalid && n < 50);
		if (!rsp.bvalid)
			bad_count++;
		rr = rsp.bresp;
		req.bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Read one word; extra edge at the end avoids re-raising in one step
	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end
		while (!rsp.rvalid && n < 50);
		if (!rsp.rvalid)
			bad_count++;
		rd = rsp.rdata;
		rr = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		rdr(a);
		`CHK(nm, e, rd)
	endtask

	task automatic close_out();
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the roughly 150 cycles the tests need
	initial
	begin
		repeat (3000) @(posedge sys_clk);
		bad_count++;
		close_out();
	end

	// Main sequence
	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rchk(OFS_POLARITY, 32'h0, "polarity");
		rchk(OFS_BYPASS, 32'h0, "bypass");
		rchk(OFS_OUT_EN, 32'h0, "out_en");
		rchk(OFS_SECURE, 32'h0, "secure");
		rchk(OFS_STATUS, 32'h0, "status in por");
		repeat (50) @(posedge sys_clk);
		rchk(OFS_STATUS, 32'h03FF_0001, "status run");
		`CHK("pin inverted", 10'h000, pin_out)
		// Mixed polarity, outputs on
		nxt <= 10'h155;
		wr(OFS_POLARITY, 32'h3E0);
		`CHK("bresp", RESP_OKAY, rr)
		wr(OFS_OUT_EN, 32'h3FF);
		repeat (2) @(posedge sys_clk);
		`CHK("pin pol", 10'h14A, pin_out)
		`CHK("oe on", 10'h3FF, pin_oe)
		// Shared set, then clear together with set
		set_t <= 1'b1;
		@(posedge sys_clk);
		rchk(OFS_STATUS, 32'h03FF_0001, "set");
		`CHK("pin set", 10'h3E0, pin_out)
		clr_t <= 1'b1;
		rchk(OFS_STATUS, 32'h0000_0001, "clear over set");
		`CHK("pin clear", 10'h01F, pin_out)
		set_t <= 1'b0;
		clr_t <= 1'b0;
		@(posedge sys_clk);
		rchk(OFS_STATUS, 32'h0155_0001, "next state");
		// Bypass low nibble: feedback from pin, else inverted flop
		wr(OFS_POLARITY, 32'h3FF);
		wr(OFS_BYPASS, 32'h00F);
		repeat (2) @(posedge sys_clk);
		`CHK("pin byp", 10'h155, pin_out)
		`CHK("fb byp", 10'h2A5, fb)
		wr(OFS_BYPASS, 32'h0);
		// Preload: enter, drive pins, clock, release, leave
		pre <= 1'b1;
		@(posedge sys_clk);
		drv <= 1'b1;
		dval <= 10'h2AA;
		@(posedge sys_clk);
		rchk(OFS_STATUS, 32'h02AA_0003, "preload");
		`CHK("oe off", 10'h000, pin_oe)
		`CHK("fb preload", 10'h155, fb)
		drv <= 1'b0;
		@(posedge sys_clk);
		pre <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK("oe back", 10'h3FF, pin_oe)
		// Security fuse masks readback and cannot be cleared by a write
		wr(OFS_PATTERN, 32'h1234_5678);
		rchk(OFS_PATTERN, 32'h1234_5678, "pattern");
		wr(OFS_SECURE, 32'h1);
		rchk(OFS_PATTERN, PATTERN_SECURED, "pattern secured");
		wr(OFS_SECURE, 32'h0);
		rchk(OFS_SECURE, 32'h1, "secure sticky");
		rchk(OFS_STATUS, 32'h0155_0005, "status secure");
		// Unmapped place
		wr(8'h40, 32'hFFFF_FFFF);
		`CHK("bresp unmapped", RESP_SLVERR, rr)
		rdr(8'h40);
		`CHK("rdata unmapped", 32'h0, rd)
		`CHK("rresp unmapped", RESP_SLVERR, rr)
		close_out();
	end
endmodule
